// ---- design/acs_sequencer.sv ----
// Conversion sequencer for a successive-approximation converter, with its register bus.
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RL1] A control-one write starts a software conversion; hardware mode starts on trigger.
// [RL2] Continuous mode relaunches after every result transfer until aborted.
// [RL3] Result transfer sets the completion flag; interrupt follows when enabled.
// [RL4] In 10-bit mode a read high byte blocks transfers until low is read.
// [RL5] A blocked transfer restarts, except single compare conversions whose test failed.
// [RL6] Software should not read results during a single conversion.
// [RL7] A control-one write aborts, then restarts in software mode unless channel is all ones.
// [RL8] Writes to control-two, config or compare registers abort the conversion.
// [RL9] Reset, or stop without the asynchronous clock, aborts the conversion.
// [RL10] Aborts keep the last results; reset clears them.
// [RL11] Idle until started; asynchronous clock enabled only while active and selected.
// [RL12] Sample short or long, then approximate, then transfer.
// [RL13] First short conversion: 20 or 23 conversion clocks plus 5 bus clocks.
// [RL14] First long conversion: 40 or 43 conversion clocks plus 5 bus clocks.
// [RL15] Asynchronous clock adds 5 us startup to a first conversion.
// [RL16] Later continuous conversions take 17, 20, 37 or 40 conversion clocks.
// [RL17] With compare on, result plus negated compare value is stored.
// [RL18] Greater select: condition is result at or above value, else below.
// [RL19] Failed compare leaves the flag clear and results untouched.
// [RL20] Wait or async stop3 finish work; only hardware or continuous starts; wake on done.
// [RL21] Stop3 without asynchronous clock idles; a fresh trigger is needed after.
// [RL22] Stop1 or stop2 returns every register to reset.
// [RL23] Disabled in reset and while channel select is all ones.
// [RL24] Trigger rising edges start; edges while busy are ignored.
// [RL25] Round to 10 bits across both bytes, or 8 bits in the low byte.
// [RL26] The trigger pin is synchronised before the state machine uses it.
module acs_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write address and data
  input wire logic [acs_pkg::ACS_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [acs_pkg::ACS_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [acs_pkg::ACS_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [acs_pkg::ACS_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Chip-level trigger, clock and power modes
  input wire logic hw_trigger_input,
  input wire logic alternate_clock,
  input wire logic wait_mode,
  input wire logic stop3_mode,
  input wire logic stop12_mode,
  // Analog core
  input wire logic [acs_pkg::ACS_RAW_W-1:0] sar_result,
  output logic sample_en,
  output logic sar_en,
  output logic async_clk_en,
  output logic low_power_config,
  // Status
  output logic conversion_active,
  output logic conversion_irq,
  output logic wake_request
);
  import acs_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic conversion_complete_flag, complete_irq_enable, continuous_enable, trg, compare_enable, compare_greater_select, read_lock;
  logic [4:0] chan;
  logic [7:0] cfg, cv_lo, res_lo, rd_byte;
  logic [1:0] cv_hi, res_hi, iclk, src_cnt;
  logic [2:0] trig_sync, alt_sync, div_cnt, div_mask;
  logic [9:0] phase, sample_len, sar_len, res_val, cv, diff;
  logic [10:0] sum10;
  logic [8:0] sum8;
  acs_state_t state;
  logic clr, wr_go, wr_en, wr_map, wr_sc1, wr_sc2, wr_cfg, wr_cvh, wr_cvl;
  logic rd_go, rd_map, rd_rh, rd_rl, trig_edge, alt_edge, src_tick, conversion_clock_tick;
  logic mode10, async_sel, low_pw, ch_off, stop_abort, sw_start, hw_start, abort;
  logic step, last, cmp_ge, cmp_ok, blocked, xfer_now, transfer, restart;

  // Stop1 and stop2 wipe registers, state and results as reset does, but not the bus or clock flops.
  assign clr = srst | stop12_mode; // [RL22]

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  // Address and data are taken together; this costs a cycle but needs no skid storage.
  assign wr_go = awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign wr_en = wr_go & wstrb[0];

  always_comb
  begin
    wr_sc1 = 1'b0;
    wr_sc2 = 1'b0;
    wr_cfg = 1'b0;
    wr_cvh = 1'b0;
    wr_cvl = 1'b0;
    wr_map = 1'b1;
    if (awaddr == ACS_SC1_ADDR)
      wr_sc1 = wr_en;
    else if (awaddr == ACS_SC2_ADDR)
      wr_sc2 = wr_en;
    else if (awaddr == ACS_CFG_ADDR)
      wr_cfg = wr_en;
    else if (awaddr == ACS_CVH_ADDR)
      wr_cvh = wr_en;
    else if (awaddr == ACS_CVL_ADDR)
      wr_cvl = wr_en;
    else if (awaddr != ACS_RH_ADDR && awaddr != ACS_RL_ADDR)
      wr_map = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bvalid <= 1'b0;
      bresp <= ACS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_map ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  assign arready = ~rvalid;
  assign rd_go = arvalid & ~rvalid;
  assign rd_rh = rd_go & (araddr == ACS_RH_ADDR);
  assign rd_rl = rd_go & (araddr == ACS_RL_ADDR);

  always_comb
  begin
    rd_byte = '0;
    rd_map = 1'b1;
    if (araddr == ACS_SC1_ADDR)
      rd_byte = {conversion_complete_flag, complete_irq_enable, continuous_enable, chan};
    else if (araddr == ACS_SC2_ADDR)
      rd_byte = {conversion_active, trg, compare_enable, compare_greater_select, 4'h0};
    else if (araddr == ACS_CFG_ADDR)
      rd_byte = cfg;
    else if (araddr == ACS_CVH_ADDR)
      rd_byte = {6'h00, cv_hi};
    else if (araddr == ACS_CVL_ADDR)
      rd_byte = cv_lo;
    else if (araddr == ACS_RH_ADDR)
      rd_byte = {6'h00, res_hi};
    else if (araddr == ACS_RL_ADDR)
      rd_byte = res_lo;
    else
      rd_map = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ACS_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rdata <= ACS_DW'(rd_byte);
      rresp <= rd_map ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      complete_irq_enable <= 1'b0;
      continuous_enable <= 1'b0;
      chan <= ACS_CH_OFF;
      trg <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater_select <= 1'b0;
      cfg <= ACS_CFG_RESET;
      cv_hi <= '0;
      cv_lo <= '0;
    end
    else
    begin
      if (wr_sc1)
      begin
        complete_irq_enable <= wdata[ACS_SC1_COMPLETE_IRQ_ENABLE];
        continuous_enable <= wdata[ACS_SC1_CONTINUOUS_ENABLE];
        chan <= wdata[4:0];
      end
      if (wr_sc2)
      begin
        trg <= wdata[ACS_SC2_TRG];
        compare_enable <= wdata[ACS_SC2_COMPARE_ENABLE];
        compare_greater_select <= wdata[ACS_SC2_COMPARE_GREATER_SELECT];
      end
      if (wr_cfg)
        cfg <= wdata[7:0];
      if (wr_cvh)
        cv_hi <= wdata[1:0];
      if (wr_cvl)
        cv_lo <= wdata[7:0];
    end
  end

  // The flag set by a transfer wins over a software clear in the same cycle, but not over clr.
  always_ff @(posedge mclk)
  begin
    if (clr)
      conversion_complete_flag <= 1'b0;
    else if (transfer)
      conversion_complete_flag <= 1'b1; // [RL3]
    else if (wr_sc1 | rd_rl)
      conversion_complete_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (clr)
      read_lock <= 1'b0;
    else if (rd_rl)
      read_lock <= 1'b0;
    else if (rd_rh)
      read_lock <= 1'b1; // [RL4]
  end

  assign iclk = cfg[ACS_CFG_ICLK +: 2];
  assign mode10 = cfg[ACS_CFG_MODE +: 2] == ACS_MODE_10;
  assign async_sel = iclk == ACS_ICLK_ASYNC;
  assign low_power_config = cfg[ACS_CFG_LPC];

  // ****************************************************************
  // Trigger synchroniser and conversion clock
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      trig_sync <= '0;
      alt_sync <= '0;
    end
    else
    begin
      trig_sync <= {trig_sync[1:0], hw_trigger_input}; // [RL26]
      alt_sync <= {alt_sync[1:0], alternate_clock};
    end
  end

  assign trig_edge = trig_sync[1] & ~trig_sync[2];
  assign alt_edge = alt_sync[1] & ~alt_sync[2];

  always_ff @(posedge mclk)
  begin
    if (srst)
      src_cnt <= '0;
    else
      src_cnt <= src_cnt + 2'h1;
  end

  always_comb
  begin
    case (iclk)
      ACS_ICLK_BUS: src_tick = 1'b1;
      ACS_ICLK_HALF: src_tick = src_cnt[0];
      ACS_ICLK_ALT: src_tick = alt_edge;
      default: src_tick = src_cnt == ACS_ASYNC_DIV;
    endcase
  end

  assign div_mask = 3'((4'h1 << cfg[ACS_CFG_DIV +: 2]) - 4'h1);
  assign conversion_clock_tick = src_tick & ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge mclk)
  begin
    if (srst)
      div_cnt <= '0;
    else if (src_tick)
      div_cnt <= div_cnt + 3'h1;
  end

  // ****************************************************************
  // Start, abort and completion decisions
  // ****************************************************************
  assign low_pw = wait_mode | stop3_mode;
  assign ch_off = chan == ACS_CH_OFF;
  assign stop_abort = stop3_mode & ~async_sel; // [RL9] [RL21]
  assign sw_start = wr_sc1 & (wdata[4:0] != ACS_CH_OFF) & ~trg & ~low_pw; // [RL1] [RL7] [RL20]
  // A trigger edge that meets a register write is dropped, since the write changes the mode.
  assign hw_start = trig_edge & trg & ~ch_off & (state == ACS_IDLE) & ~abort; // [RL24] [RL23]
  assign abort = wr_sc1 | wr_sc2 | wr_cfg | wr_cvh | wr_cvl | stop_abort; // [RL7] [RL8]

  always_comb
  begin
    sum10 = {1'b0, sar_result[10:1]} + 11'(sar_result[0]);
    sum8 = {1'b0, sar_result[10:3]} + 9'(sar_result[2]);
    if (mode10)
      res_val = sum10[10] ? '1 : sum10[9:0]; // [RL25]
    else
      res_val = sum8[8] ? ACS_MAX8 : {2'h0, sum8[7:0]};
    cv = mode10 ? {cv_hi, cv_lo} : {2'h0, cv_lo};
    diff = res_val + ~cv + 10'h001; // [RL17]
    cmp_ge = res_val >= cv;
    cmp_ok = ~compare_enable | (compare_greater_select ? cmp_ge : ~cmp_ge); // [RL18]
  end

  assign blocked = mode10 & read_lock; // [RL4]
  assign xfer_now = (state == ACS_XFER) & ~abort;
  assign transfer = xfer_now & cmp_ok & ~blocked; // [RL19]
  assign restart = xfer_now & (continuous_enable | (blocked & cmp_ok)); // [RL2] [RL5]

  // ****************************************************************
  // Conversion state machine
  // ****************************************************************
  assign sample_len = cfg[ACS_CFG_LSMP] ? ACS_SAMPLE_LONG : ACS_SAMPLE_SHORT; // [RL12]
  assign sar_len = mode10 ? ACS_SAR_10 : ACS_SAR_8;
  assign step = (state == ACS_STARTUP) | conversion_clock_tick;
  assign last = step & (phase == 10'h001);

  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      state <= ACS_IDLE; // [RL9] [RL23]
      phase <= '0;
    end
    else if (sw_start | hw_start)
    begin
      state <= async_sel ? ACS_STARTUP : ACS_SETUP; // [RL15]
      phase <= async_sel ? ACS_START_CNT : ACS_FIRST_SETUP; // [RL13] [RL14]
    end
    else if (abort)
      state <= ACS_IDLE;
    else
    begin
      case (state)
        ACS_STARTUP:
          if (last)
          begin
            state <= ACS_SETUP;
            phase <= ACS_FIRST_SETUP;
          end
          else
            phase <= phase - 10'h001;
        ACS_SETUP, ACS_SAMPLE, ACS_SAR:
          if (last)
          begin
            state <= state == ACS_SETUP ? ACS_SAMPLE : state == ACS_SAMPLE ? ACS_SAR : ACS_XFER;
            phase <= state == ACS_SETUP ? sample_len : sar_len;
          end
          else if (step)
            phase <= phase - 10'h001;
        ACS_XFER:
          if (restart)
          begin
            state <= ACS_SAMPLE; // [RL16]
            phase <= sample_len;
          end
          else
            state <= ACS_IDLE;
        default:
          phase <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Results and outputs
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      res_hi <= '0; // [RL10]
      res_lo <= '0;
    end
    else if (transfer)
    begin
      res_hi <= mode10 ? (compare_enable ? diff[9:8] : res_val[9:8]) : 2'h0;
      res_lo <= compare_enable ? diff[7:0] : res_val[7:0]; // [RL17] [RL25]
    end
  end

  assign conversion_active = state != ACS_IDLE;
  assign async_clk_en = conversion_active & async_sel; // [RL11]
  assign sample_en = state == ACS_SAMPLE;
  assign sar_en = state == ACS_SAR;
  assign conversion_irq = conversion_complete_flag & complete_irq_enable; // [RL3]
  assign wake_request = conversion_irq & low_pw; // [RL20]

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Results are only checked while no stop1 or stop2 wipe is under way.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_sw_start_runs: assert property (sw_start && !stop12_mode |=> state inside {ACS_SETUP, ACS_STARTUP}) // [RL1]
    else $error("software start did not launch a conversion");
  chk_cont_relaunch: assert property (transfer && continuous_enable && !stop12_mode |=> state == ACS_SAMPLE) // [RL2]
    else $error("continuous mode did not relaunch");
  chk_flag_on_xfer: assert property (transfer && !stop12_mode |=> conversion_complete_flag ##0 conversion_irq == complete_irq_enable) // [RL3]
    else $error("completion flag missing after transfer");
  chk_block_holds: assert property (xfer_now && blocked && !stop12_mode |=> $stable({res_hi, res_lo}) && !$rose(conversion_complete_flag)) // [RL4]
    else $error("blocked transfer altered results");
  chk_block_restart: assert property (xfer_now && blocked && cmp_ok && !stop12_mode |=> state == ACS_SAMPLE) // [RL5]
    else $error("blocked transfer did not restart");
  chk_mode_abort: assert property ((wr_sc2 || wr_cfg || wr_cvh || wr_cvl) && !sw_start && !stop12_mode |=> state == ACS_IDLE) // [RL8]
    else $error("mode write did not abort");
  chk_abort_keeps: assert property (abort && !stop12_mode |=> $stable({res_hi, res_lo})) // [RL10]
    else $error("abort changed result registers");
  chk_stop3_idle: assert property ((stop_abort && !stop12_mode) [*2] |-> state == ACS_IDLE) // [RL9]
    else $error("stop without asynchronous clock left converter busy");
  chk_cmp_false: assert property (xfer_now && !cmp_ok && !stop12_mode |=> $stable({res_hi, res_lo}) && !$rose(conversion_complete_flag)) // [RL19]
    else $error("failed compare transferred data");
  chk_stop12_wipe: assert property (stop12_mode |=> !conversion_complete_flag && !complete_irq_enable && !trg && state == ACS_IDLE) // [RL22]
    else $error("stop1 or stop2 left state behind");

  cov_continuous: cover property (transfer && continuous_enable);
  cov_blocked: cover property (xfer_now && blocked);
  cov_hw_start: cover property (hw_start ##[1:60] transfer);
endmodule : acs_sequencer
`default_nettype wire

// ---- design/acs_pkg.sv ----
// Register map, field layout and timing constants of the conversion sequencer.
`default_nettype none
package acs_pkg;
  // ****************************************************************
  // Bus geometry and register map
  // ****************************************************************
  localparam int ACS_AW = 8;
  localparam int ACS_DW = 32;
  localparam int ACS_RAW_W = 11;
  localparam logic [ACS_AW-1:0] ACS_SC1_ADDR = 8'h00;
  localparam logic [ACS_AW-1:0] ACS_SC2_ADDR = 8'h04;
  localparam logic [ACS_AW-1:0] ACS_CFG_ADDR = 8'h08;
  localparam logic [ACS_AW-1:0] ACS_CVH_ADDR = 8'h0c;
  localparam logic [ACS_AW-1:0] ACS_CVL_ADDR = 8'h10;
  localparam logic [ACS_AW-1:0] ACS_RH_ADDR = 8'h14;
  localparam logic [ACS_AW-1:0] ACS_RL_ADDR = 8'h18;
  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Field positions and encodings
  // ****************************************************************
  localparam int ACS_SC1_COMPLETE_IRQ_ENABLE = 6;
  localparam int ACS_SC1_CONTINUOUS_ENABLE = 5;
  localparam int ACS_SC2_TRG = 6;
  localparam int ACS_SC2_COMPARE_ENABLE = 5;
  localparam int ACS_SC2_COMPARE_GREATER_SELECT = 4;
  localparam int ACS_CFG_LPC = 7;
  localparam int ACS_CFG_DIV = 5;
  localparam int ACS_CFG_LSMP = 4;
  localparam int ACS_CFG_MODE = 2;
  localparam int ACS_CFG_ICLK = 0;
  localparam logic [4:0] ACS_CH_OFF = 5'h1f;
  localparam logic [1:0] ACS_MODE_10 = 2'h2;
  localparam logic [1:0] ACS_ICLK_BUS = 2'h0;
  localparam logic [1:0] ACS_ICLK_HALF = 2'h1;
  localparam logic [1:0] ACS_ICLK_ALT = 2'h2;
  localparam logic [1:0] ACS_ICLK_ASYNC = 2'h3;
  localparam logic [1:0] ACS_ASYNC_DIV = 2'h3;
  localparam logic [7:0] ACS_CFG_RESET = 8'h00;
  localparam logic [9:0] ACS_MAX8 = 10'h0ff;
  // ****************************************************************
  // Timing, in conversion-clock cycles unless named otherwise; the startup count is in bus-clock cycles
  // ****************************************************************
  localparam int ACS_CLK_NS = 8;
  localparam int ACS_ASYNC_START_NS = 5000;
  localparam int ACS_ASYNC_START_CYC = (ACS_ASYNC_START_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
  localparam logic [9:0] ACS_START_CNT = 10'(ACS_ASYNC_START_CYC);
  localparam logic [9:0] ACS_FIRST_SETUP = 10'h003;
  localparam logic [9:0] ACS_SAMPLE_SHORT = 10'h003;
  localparam logic [9:0] ACS_SAMPLE_LONG = 10'h017;
  localparam logic [9:0] ACS_SAR_8 = 10'h00e;
  localparam logic [9:0] ACS_SAR_10 = 10'h011;
  typedef enum logic [2:0] {ACS_IDLE, ACS_STARTUP, ACS_SETUP, ACS_SAMPLE, ACS_SAR, ACS_XFER}
    acs_state_t;
endpackage : acs_pkg
`default_nettype wire

// ---- bench/adc_conversion_sequencer_bench.sv ----
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_bench;
  import acs_pkg::*;
  // ****************************************************************
  // Stimulus, observed outputs and counters
  // ****************************************************************
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [ACS_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [ACS_DW-1:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic hw_trigger_input = 1'b0, stop3_mode = 1'b0, stop12_mode = 1'b0, wait_mode = 1'b0;
  logic [3:0] wstrb = 4'h1;
  logic [ACS_RAW_W-1:0] sar_result = 11'h2a5;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_resp;
  logic [ACS_DW-1:0] rdata, rd_val;
  logic sample_en, sar_en, async_clk_en, low_power_config;
  logic conversion_active, conversion_irq, wake_request;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // The alternate clock is tied low; that clock source stays untested.
  acs_sequencer dut (
    .mclk(mclk), .srst(srst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hw_trigger_input(hw_trigger_input), .alternate_clock(1'b0), .wait_mode(wait_mode),
    .stop3_mode(stop3_mode), .stop12_mode(stop12_mode), .sar_result(sar_result),
    .sample_en(sample_en), .sar_en(sar_en), .async_clk_en(async_clk_en),
    .low_power_config(low_power_config), .conversion_active(conversion_active),
    .conversion_irq(conversion_irq), .wake_request(wake_request)
  );

  always #4 mclk = ~mclk;

  // A hang anywhere ends the run as a failure rather than stalling it.
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(bresp, er);
  endtask : wr

  task automatic rd_raw(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_val = rdata;
    rd_resp = rresp;
  endtask : rd_raw

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_raw(a);
    check(rd_resp, ACS_RESP_OKAY);
    check(rd_val, {24'h0, exp});
  endtask : rd

  // The count starts at the write response, so it slightly undercounts the budget.
  task automatic wait_idle();
    n = 0;
    do
    begin
      @(posedge mclk);
      n = n + 1;
    end
    while (conversion_active !== 1'b0 && n < 2000);
  endtask : wait_idle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset_map();
    rd(ACS_SC1_ADDR, 8'h1f);
    wstrb <= 4'h0;
    wr(ACS_CFG_ADDR, 8'h55, ACS_RESP_OKAY);
    wstrb <= 4'h1;
    rd(ACS_CFG_ADDR, ACS_CFG_RESET);
    rd(ACS_RH_ADDR, 8'h00);
    rd(ACS_RL_ADDR, 8'h00);
    rd_raw(8'h1c);
    check(rd_resp, ACS_RESP_SLVERR);
    check(rd_val, 32'h0);
    wr(8'h20, 8'h55, ACS_RESP_SLVERR);
    wr(ACS_SC1_ADDR, 8'h1f, ACS_RESP_OKAY);
    repeat (4) @(posedge mclk);
    check(conversion_active, 32'h0);
  endtask : sc_reset_map

  task automatic sc_single8();
    wr(ACS_SC1_ADDR, 8'h41, ACS_RESP_OKAY);
    check(conversion_active, 32'h1);
    wait_idle();
    check(n >= 17 && n <= 25, 32'h1);
    check(conversion_irq, 32'h1);
    rd(ACS_SC1_ADDR, 8'hc1);
    rd(ACS_RH_ADDR, 8'h00);
    rd(ACS_RL_ADDR, 8'h55);
    check(conversion_irq, 32'h0);
  endtask : sc_single8

  task automatic sc_block10();
    wr(ACS_CFG_ADDR, 8'h08, ACS_RESP_OKAY);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    wait_idle();
    rd(ACS_RH_ADDR, 8'h01);
    sar_result <= 11'h100;
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    repeat (60) @(posedge mclk);
    rd(ACS_SC1_ADDR, 8'h01);
    rd(ACS_RL_ADDR, 8'h53);
    wait_idle();
    rd(ACS_SC1_ADDR, 8'h81);
    rd(ACS_RH_ADDR, 8'h00);
    rd(ACS_RL_ADDR, 8'h80);
    sar_result <= 11'h2a5;
    wr(ACS_CFG_ADDR, 8'h00, ACS_RESP_OKAY);
  endtask : sc_block10

  task automatic sc_continuous();
    wr(ACS_SC1_ADDR, 8'h21, ACS_RESP_OKAY);
    do rd_raw(ACS_SC1_ADDR); while (rd_val[7] !== 1'b1 && cycles < 20000);
    check(conversion_active, 32'h1);
    wr(ACS_SC2_ADDR, 8'h00, ACS_RESP_OKAY);
    repeat (2) @(posedge mclk);
    check(conversion_active, 32'h0);
    rd(ACS_RL_ADDR, 8'h55);
  endtask : sc_continuous

  task automatic sc_hw_trigger();
    wr(ACS_SC2_ADDR, 8'h40, ACS_RESP_OKAY);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    repeat (4) @(posedge mclk);
    check(conversion_active, 32'h0);
    hw_trigger_input <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n = n + 1;
    end
    while (conversion_active !== 1'b1 && n < 20);
    check(n <= 8, 32'h1);
    hw_trigger_input <= 1'b0;
    repeat (3) @(posedge mclk);
    hw_trigger_input <= 1'b1;
    wait_idle();
    repeat (8) @(posedge mclk);
    check(conversion_active, 32'h0);
    rd(ACS_SC1_ADDR, 8'h81);
    hw_trigger_input <= 1'b0;
    wr(ACS_SC2_ADDR, 8'h00, ACS_RESP_OKAY);
  endtask : sc_hw_trigger

  task automatic sc_compare();
    wr(ACS_CVL_ADDR, 8'h40, ACS_RESP_OKAY);
    wr(ACS_SC2_ADDR, 8'h30, ACS_RESP_OKAY);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    repeat (3) @(posedge mclk);
    check(sample_en, 32'h1);
    repeat (3) @(posedge mclk);
    check(sample_en, 32'h0);
    check(sar_en, 32'h1);
    wait_idle();
    rd(ACS_SC1_ADDR, 8'h81);
    rd(ACS_RL_ADDR, 8'h15);
    wr(ACS_SC2_ADDR, 8'h20, ACS_RESP_OKAY);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    wait_idle();
    rd(ACS_SC1_ADDR, 8'h01);
    rd(ACS_RL_ADDR, 8'h15);
    wr(ACS_SC2_ADDR, 8'h00, ACS_RESP_OKAY);
  endtask : sc_compare

  task automatic sc_wait();
    wr(ACS_SC1_ADDR, 8'h41, ACS_RESP_OKAY);
    wait_mode <= 1'b1;
    wait_idle();
    check(conversion_irq, 32'h1);
    check(wake_request, 32'h1);
    wr(ACS_SC1_ADDR, 8'h41, ACS_RESP_OKAY);
    repeat (2) @(posedge mclk);
    check(conversion_active, 32'h0);
    check(wake_request, 32'h0);
    wr(ACS_SC2_ADDR, 8'h40, ACS_RESP_OKAY);
    hw_trigger_input <= 1'b1;
    repeat (5) @(posedge mclk);
    check(conversion_active, 32'h1);
    wait_idle();
    check(wake_request, 32'h1);
    wait_mode <= 1'b0;
    hw_trigger_input <= 1'b0;
    wr(ACS_SC2_ADDR, 8'h00, ACS_RESP_OKAY);
    check(wake_request, 32'h0);
    rd(ACS_SC1_ADDR, 8'hc1);
  endtask : sc_wait

  task automatic sc_power();
    wr(ACS_CFG_ADDR, 8'h03, ACS_RESP_OKAY);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    repeat (2) @(posedge mclk);
    check(async_clk_en, 32'h1);
    wr(ACS_CFG_ADDR, 8'h98, ACS_RESP_OKAY);
    repeat (2) @(posedge mclk);
    check(async_clk_en, 32'h0);
    check(conversion_active, 32'h0);
    check(low_power_config, 32'h1);
    wr(ACS_SC1_ADDR, 8'h01, ACS_RESP_OKAY);
    repeat (5) @(posedge mclk);
    stop3_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    check(conversion_active, 32'h0);
    stop3_mode <= 1'b0;
    repeat (5) @(posedge mclk);
    check(conversion_active, 32'h0);
    stop12_mode <= 1'b1;
    @(posedge mclk);
    stop12_mode <= 1'b0;
    rd(ACS_CFG_ADDR, ACS_CFG_RESET);
    rd(ACS_SC1_ADDR, 8'h1f);
  endtask : sc_power

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    sc_reset_map();
    sc_single8();
    sc_block10();
    sc_continuous();
    sc_hw_trigger();
    sc_compare();
    sc_wait();
    sc_power();
    wrap_up();
  end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
